// [rtl/display_out_defines.vh]
/*
 Shared constants of the display output stage: register offsets, field
 positions, reset values, mode codes and loop constants.
 Assumes it is included by its bare name from rtl/.
*/
`ifndef DISPLAY_OUT_DEFINES_VH
`define DISPLAY_OUT_DEFINES_VH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_TUNE 8'h04
`define OFF_HTIME 8'h08
`define OFF_HDE 8'h0c
`define OFF_VTIME 8'h10
`define OFF_VDE 8'h14
`define OFF_LOCK_EVENT 8'h18
`define OFF_LOCK_LOAD 8'h1c
`define OFF_SOURCE 8'h20
`define OFF_RATIO 8'h24
`define OFF_LUT_WRITE 8'h28
`define OFF_STATUS 8'h2c
`define OFF_LIVE_TUNE 8'h30

// Field ranges
`define LO 15:0
`define HI 31:16
`define CTRL_W 8:0
`define TUNE_F 29:0
`define RATIO_M 7:0
`define RATIO_N 15:8
`define RATIO_INT 23:16
`define LUT_DATA 9:0
`define LUT_ADDR 17:10
`define LUT_CH 19:18
`define RATIO_F 23:0
`define LUT_F 19:0
`define ACC_MSB 29
`define RND_A 3:0
`define RND_B 7:4

// Control bit positions
`define C_BYPASS 0
`define C_DITHER 1
`define C_RANDOM 2
`define C_SYNC 4:3
`define C_MANUAL 5
`define C_DOUBLE 6
`define C_PIX18 7
`define C_CLOSED 8

// Codes and reset values
`define SYNC_FREE 2'h0
`define SYNC_FRAME 2'h1
`define CH_R 2'h0
`define CH_G 2'h1
`define CH_B 2'h2
`define CH_ALL 2'h3
`define CTRL_RESET 9'h001
`define TUNE_RESET 30'h10000000
`define TUNE_MAX 30'h20000000
`define TUNE_MIN 30'h00000001
`define TRIM_STEP 30'h00000100
`define LFSR_SEED 16'hace1
`define LFSR_TAPS 16'hb400
`define STEP_ONE 16'h0001
`define STEP_TWO 16'h0002
`define COUNT_ONE 8'h01

`endif

// [rtl/gamma_dither.v]
/*
 Per-channel gamma table (8 in, 10 out) with bypass, followed by ordered
 or random dithering down to the port depth. One pixel per instance.
 Assumes writes and pixel reads come on the same clock; the read is
 combinational, the parent registers the result.
*/
`timescale 1ns/1ps
`include "display_out_defines.vh"

module gamma_dither (
    input wire pclk,
    input wire lut_we,
    input wire [1:0] lut_ch,
    input wire [7:0] lut_addr,
    input wire [9:0] lut_data,
    input wire bypass,
    input wire dither_en,
    input wire six_bit,
    input wire random_sel,
    input wire x0,
    input wire y0,
    input wire frame_odd,
    input wire [3:0] rnd,
    input wire [23:0] pixel_in,
    output reg [23:0] pixel_out
);

reg [9:0] lut_r [0:255];
reg [9:0] lut_g [0:255];
reg [9:0] lut_b [0:255];
reg [1:0] bayer;
reg [3:0] noise;
reg [9:0] r10;
reg [9:0] g10;
reg [9:0] b10;
reg [7:0] r_o;
reg [7:0] g_o;
reg [7:0] b_o;

// Bypass skips the table, so an unloaded table is harmless
function [9:0] map;
    input [7:0] v;
    input [9:0] t;
    input byp;
    begin
        map = byp ? {v, v[7:6]} : t;
    end
endfunction

// Adds noise below the kept bits, saturates, then truncates
function [7:0] reduce;
    input [9:0] v;
    input [3:0] n;
    input en;
    input six;
    reg [10:0] s;
    begin
        s = {1'b0, v};
        if (en) begin
            s = s + (six ? {7'h00, n} : {9'h000, n[1:0]});
        end
        if (s[10]) begin
            s = 11'h3ff;
        end
        reduce = six ? {2'h0, s[9:4]} : s[9:2];
    end
endfunction

always @(posedge pclk) begin
    if (lut_we && (lut_ch == `CH_R || lut_ch == `CH_ALL)) begin
        lut_r[lut_addr] <= lut_data;
    end
    if (lut_we && (lut_ch == `CH_G || lut_ch == `CH_ALL)) begin
        lut_g[lut_addr] <= lut_data;
    end
    if (lut_we && (lut_ch == `CH_B || lut_ch == `CH_ALL)) begin
        lut_b[lut_addr] <= lut_data;
    end
end

always @* begin
    // 2x2 ordered pattern, inverted on odd frames for the temporal part
    bayer = {x0 ^ y0, y0} ^ {2{frame_odd}};
    noise = random_sel ? rnd : {bayer, bayer};
    r10 = map(pixel_in[23:16], lut_r[pixel_in[23:16]], bypass);
    g10 = map(pixel_in[15:8], lut_g[pixel_in[15:8]], bypass);
    b10 = map(pixel_in[7:0], lut_b[pixel_in[7:0]], bypass);
    r_o = reduce(r10, noise, dither_en, six_bit);
    g_o = reduce(g10, noise, dither_en, six_bit);
    b_o = reduce(b10, noise, dither_en, six_bit);
    if (six_bit) begin
        pixel_out = {6'h00, r_o[5:0], g_o[5:0], b_o[5:0]};
    end else begin
        pixel_out = {r_o, g_o, b_o};
    end
end

endmodule // gamma_dither

// [rtl/display_output_timing_gamma.v]
/*
 Display output stage: APB registers, display clock synthesizer (phase
 accumulator, open or closed loop), display timing generator with free-run,
 frame-sync and manual sync, and two gamma/dither pixel lanes.
 Assumes all inputs are synchronous to pclk except the manual sync pin,
 and that input timing arrives as one-pclk pulses per input pixel.
 // Function
 // - Per-channel 8-in 10-out gamma table
 // - Optional dither of table output to 8/6 bits
 // - Spatial-temporal dither, ordered or random selectable
 // - Host bypass passes pixels unmapped
 // - Table writes per channel or all three
 // - 18/24-bit port, one or two pixels
 // - Outputs change with display pixel clock
 // - Open loop: 30-bit tuning word synthesizer
 // - Closed loop scales input clock by ratio
 // - Free-run uses registers only, open loop
 // - Lock event reloads counters with lock-load
 // - Alignment every N input frames
 // - Enabled manual sync pin forces lock-load
 // - Sync and data-valid from timing registers
 // - Counts from sync leading edges
*/
`timescale 1ns/1ps
`include "display_out_defines.vh"

module display_output_timing_gamma (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire input_pixel_tick,
    input wire input_line_start,
    input wire input_frame_start,
    input wire manual_frame_sync_pin_n,
    input wire [23:0] pixel_in_a,
    input wire [23:0] pixel_in_b,
    output reg display_pixel_clock,
    output reg display_hsync,
    output reg display_vsync,
    output reg display_data_valid,
    output reg [47:0] display_data,
    output reg pixel_take
);

reg [8:0] ctrl_reg;
reg [29:0] tune_reg;
reg [31:0] htime_reg;
reg [31:0] hde_reg;
reg [31:0] vtime_reg;
reg [31:0] vde_reg;
reg [31:0] lock_event_reg;
reg [31:0] lock_load_reg;
reg [31:0] source_reg;
reg [23:0] ratio_reg;
reg lut_we_reg;
reg [19:0] lut_wdata_reg;
reg [29:0] live_tune_reg;
reg [29:0] acc_reg;
reg [15:0] h_cnt_reg;
reg [15:0] v_cnt_reg;
reg frame_odd_reg;
reg [15:0] lfsr_reg;
reg [15:0] src_h_reg;
reg [15:0] src_v_reg;
reg [7:0] lock_cnt_reg;
reg reload_reg;
reg [2:0] msync_reg;
reg [39:0] src_pix_reg;
reg [39:0] disp_pix_reg;

wire [23:0] lane_a;
wire [23:0] lane_b;
wire [29:0] acc_next = acc_reg + live_tune_reg;
wire tick = ~acc_reg[`ACC_MSB] & acc_next[`ACC_MSB];
wire setup = psel & ~penable;
wire wr = psel & penable & pwrite;
wire frame_mode = ctrl_reg[`C_SYNC] == `SYNC_FRAME;
wire closed_eff = ctrl_reg[`C_CLOSED] & frame_mode;
wire [15:0] step = ctrl_reg[`C_DOUBLE] ? `STEP_TWO : `STEP_ONE;
wire [15:0] h_step = h_cnt_reg + step;
wire [15:0] v_step = v_cnt_reg + `STEP_ONE;
wire h_wrap = h_step >= htime_reg[`LO];
wire v_wrap = v_step >= vtime_reg[`LO];
wire [15:0] cur_h = input_line_start ? 16'h0000 : src_h_reg + `STEP_ONE;
wire [15:0] cur_v = input_frame_start ? 16'h0000 :
                    (input_line_start ? src_v_reg + `STEP_ONE : src_v_reg);
wire lock_hit = input_pixel_tick & frame_mode & (cur_h == lock_event_reg[`LO]) &
                (cur_v == lock_event_reg[`HI]);
wire [7:0] interval = ratio_reg[`RATIO_INT];
wire lock_due = (lock_cnt_reg + `COUNT_ONE >= interval);
wire manual_fall = msync_reg[2] & ~msync_reg[1];
wire reload_set = (lock_hit & lock_due) | (manual_fall & ctrl_reg[`C_MANUAL]);
wire [39:0] src_target = prod3(source_reg[`LO], source_reg[`HI], ratio_reg[`RATIO_N]);
wire [39:0] disp_target = prod3(htime_reg[`LO], vtime_reg[`LO], ratio_reg[`RATIO_M]);
wire window_end = closed_eff & input_pixel_tick & (src_pix_reg + 40'h1 >= src_target);
wire [29:0] tune_up = live_tune_reg + `TRIM_STEP;
wire [29:0] tune_dn = live_tune_reg - `TRIM_STEP;

reg [31:0] rdata_next;
reg decode_ok;

// Product of two totals and a frame count, wide enough for any setting
function [39:0] prod3;
    input [15:0] a;
    input [15:0] b;
    input [7:0] c;
    begin
        prod3 = {24'h000000, a} * {24'h000000, b} * {32'h00000000, c};
    end
endfunction

function in_range;
    input [15:0] v;
    input [31:0] bounds;
    begin
        in_range = (v >= bounds[`LO]) && (v < bounds[`HI]);
    end
endfunction

always @* begin
    decode_ok = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr)
        `OFF_CTRL: rdata_next = {23'h000000, ctrl_reg};
        `OFF_TUNE: rdata_next = {2'h0, tune_reg};
        `OFF_HTIME: rdata_next = htime_reg;
        `OFF_HDE: rdata_next = hde_reg;
        `OFF_VTIME: rdata_next = vtime_reg;
        `OFF_VDE: rdata_next = vde_reg;
        `OFF_LOCK_EVENT: rdata_next = lock_event_reg;
        `OFF_LOCK_LOAD: rdata_next = lock_load_reg;
        `OFF_SOURCE: rdata_next = source_reg;
        `OFF_RATIO: rdata_next = {8'h00, ratio_reg};
        `OFF_LUT_WRITE: rdata_next = {12'h000, lut_wdata_reg};
        `OFF_STATUS: rdata_next = {v_cnt_reg, h_cnt_reg};
        `OFF_LIVE_TUNE: rdata_next = {2'h0, live_tune_reg};
        default: decode_ok = 1'b0;
    endcase
end

// Zero-wait slave; read data is captured in the setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b1;
        pslverr <= 1'b0;
        ctrl_reg <= `CTRL_RESET;
        tune_reg <= `TUNE_RESET;
        htime_reg <= 32'h00000000;
        hde_reg <= 32'h00000000;
        vtime_reg <= 32'h00000000;
        vde_reg <= 32'h00000000;
        lock_event_reg <= 32'h00000000;
        lock_load_reg <= 32'h00000000;
        source_reg <= 32'h00000000;
        ratio_reg <= 24'h000000;
        lut_we_reg <= 1'b0;
        lut_wdata_reg <= 20'h00000;
    end else begin
        pready <= 1'b1;
        lut_we_reg <= 1'b0;
        if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rdata_next;
            pslverr <= ~decode_ok;
        end
        if (wr) begin
            case (paddr)
                `OFF_CTRL: ctrl_reg <= pwdata[`CTRL_W];
                `OFF_TUNE: tune_reg <= pwdata[`TUNE_F];
                `OFF_HTIME: htime_reg <= pwdata;
                `OFF_HDE: hde_reg <= pwdata;
                `OFF_VTIME: vtime_reg <= pwdata;
                `OFF_VDE: vde_reg <= pwdata;
                `OFF_LOCK_EVENT: lock_event_reg <= pwdata;
                `OFF_LOCK_LOAD: lock_load_reg <= pwdata;
                `OFF_SOURCE: source_reg <= pwdata;
                `OFF_RATIO: ratio_reg <= pwdata[`RATIO_F];
                `OFF_LUT_WRITE: begin
                    lut_wdata_reg <= pwdata[`LUT_F];
                    lut_we_reg <= 1'b1;
                end
                default: ;
            endcase
        end
    end
end

// Synthesizer: the accumulator MSB is the display pixel clock
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        acc_reg <= 30'h00000000;
        display_pixel_clock <= 1'b0;
        live_tune_reg <= `TUNE_RESET;
        src_pix_reg <= 40'h0000000000;
        disp_pix_reg <= 40'h0000000000;
    end else begin
        acc_reg <= acc_next;
        display_pixel_clock <= acc_next[`ACC_MSB];
        if (!closed_eff) begin
            live_tune_reg <= tune_reg;
            src_pix_reg <= 40'h0000000000;
            disp_pix_reg <= 40'h0000000000;
        end else if (window_end) begin
            // Source pixels of N frames vs display pixels of M frames
            if (disp_pix_reg < disp_target && live_tune_reg < `TUNE_MAX) begin
                live_tune_reg <= tune_up;
            end else if (disp_pix_reg > disp_target && tune_dn >= `TUNE_MIN) begin
                live_tune_reg <= tune_dn;
            end
            src_pix_reg <= 40'h0000000000;
            disp_pix_reg <= 40'h0000000000;
        end else begin
            if (input_pixel_tick) begin
                src_pix_reg <= src_pix_reg + 40'h1;
            end
            if (tick) begin
                disp_pix_reg <= disp_pix_reg + {24'h000000, step};
            end
        end
    end
end

// Input position tracking, lock event divider and manual sync
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        src_h_reg <= 16'h0000;
        src_v_reg <= 16'h0000;
        lock_cnt_reg <= 8'h00;
        msync_reg <= 3'h7;
        reload_reg <= 1'b0;
    end else begin
        msync_reg <= {msync_reg[1], msync_reg[0], manual_frame_sync_pin_n};
        if (input_pixel_tick) begin
            src_h_reg <= cur_h;
            src_v_reg <= cur_v;
        end
        if (!frame_mode) begin
            lock_cnt_reg <= 8'h00;
        end else if (lock_hit) begin
            lock_cnt_reg <= lock_due ? 8'h00 : lock_cnt_reg + `COUNT_ONE;
        end
        // A new request in the consuming cycle survives to the next pixel
        reload_reg <= reload_set | (reload_reg & ~tick);
    end
end

// Timing generator; everything here except the pixel_take clear moves only on a display clock rise
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        h_cnt_reg <= 16'h0000;
        v_cnt_reg <= 16'h0000;
        frame_odd_reg <= 1'b0;
        lfsr_reg <= `LFSR_SEED;
        display_hsync <= 1'b0;
        display_vsync <= 1'b0;
        display_data_valid <= 1'b0;
        display_data <= 48'h000000000000;
        pixel_take <= 1'b0;
    end else begin
        pixel_take <= 1'b0;
        if (tick) begin
            lfsr_reg <= lfsr_reg[0] ? (lfsr_reg >> 1) ^ `LFSR_TAPS : lfsr_reg >> 1;
            if (reload_reg) begin
                h_cnt_reg <= lock_load_reg[`LO];
                v_cnt_reg <= lock_load_reg[`HI];
            end else if (h_wrap) begin
                h_cnt_reg <= 16'h0000;
                if (v_wrap) begin
                    v_cnt_reg <= 16'h0000;
                    frame_odd_reg <= ~frame_odd_reg;
                end else begin
                    v_cnt_reg <= v_step;
                end
            end else begin
                h_cnt_reg <= h_step;
            end
            // Count zero is the sync leading edge
            display_hsync <= h_cnt_reg < htime_reg[`HI];
            display_vsync <= v_cnt_reg < vtime_reg[`HI];
            display_data_valid <= in_range(h_cnt_reg, hde_reg) &
                                  in_range(v_cnt_reg, vde_reg);
            if (in_range(h_cnt_reg, hde_reg) & in_range(v_cnt_reg, vde_reg)) begin
                pixel_take <= 1'b1;
                display_data <= ctrl_reg[`C_DOUBLE] ? {lane_b, lane_a} :
                                {24'h000000, lane_a};
            end else begin
                display_data <= 48'h000000000000;
            end
        end
    end
end

gamma_dither lane_a_inst (
    .pclk(pclk),
    .lut_we(lut_we_reg),
    .lut_ch(lut_wdata_reg[`LUT_CH]),
    .lut_addr(lut_wdata_reg[`LUT_ADDR]),
    .lut_data(lut_wdata_reg[`LUT_DATA]),
    .bypass(ctrl_reg[`C_BYPASS]),
    .dither_en(ctrl_reg[`C_DITHER]),
    .six_bit(ctrl_reg[`C_PIX18]),
    .random_sel(ctrl_reg[`C_RANDOM]),
    .x0(h_cnt_reg[0]),
    .y0(v_cnt_reg[0]),
    .frame_odd(frame_odd_reg),
    .rnd(lfsr_reg[`RND_A]),
    .pixel_in(pixel_in_a),
    .pixel_out(lane_a)
);

// Second lane costs a table copy but keeps both pixels on one clock
gamma_dither lane_b_inst (
    .pclk(pclk),
    .lut_we(lut_we_reg),
    .lut_ch(lut_wdata_reg[`LUT_CH]),
    .lut_addr(lut_wdata_reg[`LUT_ADDR]),
    .lut_data(lut_wdata_reg[`LUT_DATA]),
    .bypass(ctrl_reg[`C_BYPASS]),
    .dither_en(ctrl_reg[`C_DITHER]),
    .six_bit(ctrl_reg[`C_PIX18]),
    .random_sel(ctrl_reg[`C_RANDOM]),
    .x0(~h_cnt_reg[0]),
    .y0(v_cnt_reg[0]),
    .frame_odd(frame_odd_reg),
    .rnd(lfsr_reg[`RND_B]),
    .pixel_in(pixel_in_b),
    .pixel_out(lane_b)
);

endmodule // display_output_timing_gamma

// [tb/display_out_monitor.sv]
/*
 Port checker of the display output stage, bound to its top module.
 Assumes pclk is the only clock and presetn the asynchronous reset.
*/
`timescale 1ns/1ps

module display_out_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic display_pixel_clock,
    input wire logic display_hsync,
    input wire logic display_vsync,
    input wire logic display_data_valid,
    input wire logic [47:0] display_data,
    input wire logic pixel_take
);
    // Highest register word sits at 0x30
    wire unmapped = paddr > 8'h30 || paddr[1:0] != 2'h0;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_always_a: assert property (pready)
        else $error("pready low");
    bad_addr_err_a: assert property (psel && !penable && unmapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    good_addr_ok_a: assert property (psel && !penable && !unmapped |=> !pslverr)
        else $error("mapped access refused");
    apb_answer_hold_a: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
        else $error("read answer moved outside setup");
    take_on_tick_a: assert property (pixel_take |-> $rose(display_pixel_clock))
        else $error("pixel take off tick");
    take_one_cycle_a: assert property (pixel_take |=> !pixel_take)
        else $error("pixel take too long");
    hold_between_ticks_a: assert property (!$rose(display_pixel_clock) |->
        $stable({display_hsync, display_vsync, display_data_valid, display_data}))
        else $error("display output moved between ticks");
    blank_data_zero_a: assert property (!display_data_valid |-> display_data == 48'h0)
        else $error("data outside valid window");
endmodule // display_out_monitor

bind display_output_timing_gamma display_out_monitor display_out_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .display_pixel_clock(display_pixel_clock), .display_hsync(display_hsync),
    .display_vsync(display_vsync), .display_data_valid(display_data_valid),
    .display_data(display_data), .pixel_take(pixel_take));

// [tb/panel_model.sv]
/*
 Panel model: counts ticks, sync and valid pixels, keeps the last pixel,
 and drives the manual frame sync pin on request.
 Assumes the pixel clock is a pclk-synchronous level.
*/
`timescale 1ns/1ps

module panel_model (
    input wire pclk,
    input wire presetn,
    input wire display_pixel_clock,
    input wire display_hsync,
    input wire display_vsync,
    input wire display_data_valid,
    input wire [47:0] display_data,
    input wire clr,
    input wire sync_req,
    output reg manual_frame_sync_pin_n,
    output reg [15:0] ticks,
    output reg [15:0] valid_cnt,
    output reg [15:0] hs_cnt,
    output reg [15:0] vs_cnt,
    output reg [47:0] last_data
);
    reg clk_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q <= 1'b0;
            manual_frame_sync_pin_n <= 1'b1;
            {ticks, valid_cnt, hs_cnt, vs_cnt, last_data} <= 112'h0;
        end else begin
            clk_q <= display_pixel_clock;
            manual_frame_sync_pin_n <= !sync_req;
            if (clr) begin
                {ticks, valid_cnt, hs_cnt, vs_cnt, last_data} <= 112'h0;
            end else if (display_pixel_clock && !clk_q) begin
                // Sampled one pclk after the rise, when the outputs have settled
                ticks <= ticks + 16'h1;
                valid_cnt <= valid_cnt + {15'h0, display_data_valid};
                hs_cnt <= hs_cnt + {15'h0, display_hsync};
                vs_cnt <= vs_cnt + {15'h0, display_vsync};
                if (display_data_valid) begin
                    last_data <= display_data;
                end
            end
        end
    end
endmodule // panel_model

// [tb/display_output_timing_gamma_tb_top.sv]
/*
 Testbench of the display output stage: APB tasks, timing and pixel checks.
 Assumes the panel model and the bound port checker are compiled with it.
*/
`timescale 1ns/1ps
`include "display_out_defines.vh"

module display_output_timing_gamma_tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg input_pixel_tick = 1'b0;
    reg input_line_start = 1'b0;
    reg input_frame_start = 1'b0;
    reg [23:0] pixel_in_a = 24'h0;
    reg [23:0] pixel_in_b = 24'h0;
    reg clr = 1'b0;
    reg sync_req = 1'b0;
    reg [31:0] q;
    reg e;
    wire [31:0] prdata;
    wire pready, pslverr, manual_frame_sync_pin_n, pixel_take;
    wire display_pixel_clock, display_hsync, display_vsync, display_data_valid;
    wire [47:0] display_data, last_data;
    wire [15:0] ticks, valid_cnt, hs_cnt, vs_cnt;
    integer err_total = 0;
    integer cmp_count = 0;
    integer cyc = 0;

    always #12.5 pclk = ~pclk;

    display_output_timing_gamma display_output_timing_gamma_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_pixel_tick(input_pixel_tick), .input_line_start(input_line_start),
        .input_frame_start(input_frame_start),
        .manual_frame_sync_pin_n(manual_frame_sync_pin_n),
        .pixel_in_a(pixel_in_a), .pixel_in_b(pixel_in_b),
        .display_pixel_clock(display_pixel_clock), .display_hsync(display_hsync),
        .display_vsync(display_vsync), .display_data_valid(display_data_valid),
        .display_data(display_data), .pixel_take(pixel_take));

    panel_model panel_model_i (
        .pclk(pclk), .presetn(presetn), .display_pixel_clock(display_pixel_clock),
        .display_hsync(display_hsync), .display_vsync(display_vsync),
        .display_data_valid(display_data_valid), .display_data(display_data),
        .clr(clr), .sync_req(sync_req), .manual_frame_sync_pin_n(manual_frame_sync_pin_n),
        .ticks(ticks), .valid_cnt(valid_cnt), .hs_cnt(hs_cnt), .vs_cnt(vs_cnt),
        .last_data(last_data));

    task complete_run;
        begin
            $display("compares %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task chk(input [79:0] nm, input [47:0] ex, input [47:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== ex) begin
                err_total = err_total + 1;
                $display("unexpected %0s expected %h seen %h", nm, ex, got);
            end
        end
    endtask

    // Request held until pready is seen high with psel and penable
    task apb(input [7:0] a, input w, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // Only the bench timeout ends a stuck access
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, input [47:0] ex, input [79:0] nm);
        begin
            apb(a, 1'b0, 32'h0);
            chk(nm, ex, {16'h0, q});
        end
    endtask

    function [23:0] p18(input [23:0] p);
        p18 = {6'h0, p[23:18], p[15:10], p[7:2]};
    endfunction

    // One settling frame, then exactly 128 pclk = 32 ticks at the reset tuning
    task frame(input [47:0] dat);
        begin
            repeat (128) @(posedge pclk);
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            repeat (128) @(posedge pclk);
            #1;
            chk("ticks", 48'd32, {32'h0, ticks});
            chk("valid", 48'd8, {32'h0, valid_cnt});
            chk("hsync", 48'd8, {32'h0, hs_cnt});
            chk("vsync", 48'd8, {32'h0, vs_cnt});
            chk("data", dat, last_data);
        end
    endtask

    task wtick;
        reg [15:0] t0;
        begin
            t0 = ticks;
            while (ticks === t0) begin
                @(posedge pclk);
                #1;
            end
        end
    endtask

    // Fires an input lock event or a manual pin pulse right after a tick
    task lock(input man);
        begin
            wtick;
            @(posedge pclk);
            sync_req <= man;
            input_pixel_tick <= !man;
            input_line_start <= !man;
            input_frame_start <= !man;
            @(posedge pclk);
            input_pixel_tick <= 1'b0;
            input_line_start <= 1'b0;
            input_frame_start <= 1'b0;
            repeat (6) @(posedge pclk);
            sync_req <= 1'b0;
            wtick;
            rd(`OFF_STATUS, 48'h20005, "status");
        end
    endtask

    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            complete_run;
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFF_CTRL, 48'h1, "ctrl");
        rd(`OFF_TUNE, 48'h10000000, "tune");
        rd(`OFF_LIVE_TUNE, 48'h10000000, "live");
        rd(8'h34, 48'h0, "unmapped");
        chk("slverr", 48'h1, {47'h0, e});
        apb(`OFF_HTIME, 1'b1, 32'h00020008);
        apb(`OFF_HDE, 1'b1, 32'h00070003);
        apb(`OFF_VTIME, 1'b1, 32'h00010004);
        apb(`OFF_VDE, 1'b1, 32'h00030001);
        apb(`OFF_LOCK_LOAD, 1'b1, 32'h00020005);
        pixel_in_a <= 24'h123456;
        pixel_in_b <= 24'hfedcba;
        frame({24'h0, 24'h123456});
        apb(`OFF_CTRL, 1'b1, 32'h0c1);
        frame({p18(24'hfedcba), p18(24'h123456)});
        apb(`OFF_LUT_WRITE, 1'b1, {12'h0, `CH_ALL, 8'h12, 10'h2a8});
        apb(`OFF_LUT_WRITE, 1'b1, {12'h0, `CH_R, 8'h12, 10'h154});
        pixel_in_a <= 24'h121212;
        apb(`OFF_CTRL, 1'b1, 32'h0);
        frame({24'h0, 24'h55aaaa});
        // One valid pixel at (3,1): noise 1 or 2 by frame parity, both give 0xab
        apb(`OFF_LUT_WRITE, 1'b1, {12'h0, `CH_ALL, 8'h34, 10'h2ab});
        apb(`OFF_HDE, 1'b1, 32'h00040003);
        apb(`OFF_VDE, 1'b1, 32'h00020001);
        pixel_in_a <= 24'h343434;
        apb(`OFF_CTRL, 1'b1, 32'h002);
        repeat (256) @(posedge pclk);
        #1;
        chk("dither", {24'h0, 24'hababab}, last_data);
        // Slow tick leaves room to fire an event between two ticks
        apb(`OFF_TUNE, 1'b1, 32'h01000000);
        // One-tick source window, target 32 display pixels: tune steps up once
        apb(`OFF_SOURCE, 1'b1, 32'h00010001);
        apb(`OFF_RATIO, 1'b1, 32'h00000101);
        apb(`OFF_CTRL, 1'b1, 32'h108);
        lock(1'b0);
        rd(`OFF_LIVE_TUNE, 48'h1000100, "closed");
        apb(`OFF_CTRL, 1'b1, 32'h020);
        lock(1'b1);
        complete_run;
    end
endmodule // display_output_timing_gamma_tb_top
